// File: fra_file_reg_alu.sv
/*
  File-register ALU and branch unit: complement, decrement, increment, the two
  skip-on-zero forms and the unconditional jump, with 128 file registers, the
  accumulator, zero flag and program counter held here.
  An instruction is taken only on an instruction-cycle slot, one clock in
  every TCY_CLKS, and never while a two-cycle instruction is in progress.
  Results land at the taking edge, bar a skip's second pc step at the end of
  its second slot; taken_o and skip_o are registered one-clock pulses after it,
  done_o follows the end of the last slot, and busy_o marks the second slot.
  Only complement, decrement and increment touch the zero flag.
  A preload port and a registered peek port reach the file registers
  directly, for setup and observation; neither is visible to software.
  Assumes the issuer holds issue_valid_i and its operands until a taken slot;
  the upper jump latch is owned elsewhere and presented as a level.
  Assumes every input is synchronous to clk_i; nothing here resynchronises,
  and a preload that clashes with an executing write is simply dropped.
*/
// Behaviour
// - Complement inverts the file register; target bit picks accumulator or register; zero updated.
// - Jump loads its eleven-bit literal into program counter bits ten to zero.
// - Jump takes program counter bits twelve and eleven from latch bits four, three.
// - Jump takes two instruction cycles and changes no status flag.
// - Decrement subtracts one, routes by target bit, updates the zero flag.
// - Increment adds one, routes by target bit, updates the zero flag.
// - Decrement-and-skip subtracts one, routes by target bit, leaves flags untouched.
// - Zero decrement-and-skip result discards next instruction, runs idle, takes two cycles.
// - Increment-and-skip adds one, routes, keeps flags; zero result skips over two cycles.
// - Nonzero skip-form result lets next instruction run; one cycle, no skip.
`timescale 1ns/10ps

module fra_file_reg_alu #(
  parameter int TCY_CLKS = fra_pkg::TCY_CLKS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic issue_valid_i,
  input wire logic [2:0] issue_op_i,
  input wire logic [fra_pkg::ADDR_W-1:0] file_addr_i,
  input wire logic dest_i,
  input wire logic [fra_pkg::LIT_W-1:0] literal_i,
  input wire logic [fra_pkg::LATCH_W-1:0] upper_jump_latch_i,
  input wire logic load_valid_i,
  input wire logic [fra_pkg::ADDR_W-1:0] load_addr_i,
  input wire logic [fra_pkg::DATA_W-1:0] load_data_i,
  input wire logic [fra_pkg::ADDR_W-1:0] peek_addr_i,
  output logic [fra_pkg::DATA_W-1:0] peek_data_o,
  output logic [fra_pkg::DATA_W-1:0] accum_o,
  output logic zero_flag_o,
  output logic [fra_pkg::PC_W-1:0] pc_o,
  output logic busy_o,
  output logic taken_o,
  output logic skip_o,
  output logic done_o
);

  // Slot divider sizing; a one-clock slot still keeps one counter bit
  localparam int CNT_W = (TCY_CLKS > 1) ? $clog2(TCY_CLKS) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TCY_CLKS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // Registered state
  logic [CNT_W-1:0] div_cnt_q;
  logic tcy_en_q;
  fra_pkg::fra_state_e state_q;
  fra_pkg::fra_state_e state_d;
  logic second_skips_q;
  logic [fra_pkg::DATA_W-1:0] file_q [fra_pkg::FILE_DEPTH];
  logic [fra_pkg::DATA_W-1:0] accum_q;
  logic zero_q;
  logic [fra_pkg::PC_W-1:0] pc_q;
  logic busy_q;
  logic taken_q;
  logic skip_q;
  logic done_q;
  logic [fra_pkg::DATA_W-1:0] peek_q;

  // Decode and datapath nets
  fra_pkg::fra_op_e op;
  logic slot_last;
  logic is_jump;
  logic second_end;
  logic take;
  logic [fra_pkg::DATA_W-1:0] operand;
  logic [fra_pkg::DATA_W-1:0] result;
  logic writes_result;
  logic sets_zero;
  logic is_skip_form;
  logic result_zero;
  logic skip_now;
  logic file_wr;

  // Last clock of an instruction-cycle slot
  assign slot_last = (div_cnt_q == CNT_LAST);

  // Slot divider counts clocks within one instruction cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_q <= CNT_ZERO;
    end else if (slot_last) begin
      div_cnt_q <= CNT_ZERO;
    end else begin
      div_cnt_q <= div_cnt_q + CNT_W'(1);
    end
  end

  // Instruction-cycle enable: one pulse every TCY_CLKS clocks, registered
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tcy_en_q <= 1'b0;
    end else begin
      tcy_en_q <= slot_last;
    end
  end

  // Unknown codes fall through to idle_op in the decode below
  assign op = fra_pkg::fra_op_e'(issue_op_i);
  assign take = tcy_en_q && issue_valid_i && (state_q == fra_pkg::ST_READY);
  assign operand = file_q[file_addr_i];
  assign is_jump = (op == fra_pkg::jump_op);

  // Second slot of a two-cycle instruction closes on the next slot pulse
  assign second_end = (state_q == fra_pkg::ST_SECOND) && tcy_en_q;

  // Operation decode and arithmetic
  always_comb begin
    result = operand;
    writes_result = 1'b0;
    sets_zero = 1'b0;
    is_skip_form = 1'b0;
    case (op)
      fra_pkg::complement_op: begin
        result = ~operand;
        writes_result = 1'b1;
        sets_zero = 1'b1;
      end
      fra_pkg::decrement_op: begin
        result = operand - fra_pkg::DATA_ONE;
        writes_result = 1'b1;
        sets_zero = 1'b1;
      end
      fra_pkg::increment_op: begin
        result = operand + fra_pkg::DATA_ONE;
        writes_result = 1'b1;
        sets_zero = 1'b1;
      end
      fra_pkg::decrement_skip_zero_op: begin
        result = operand - fra_pkg::DATA_ONE;
        writes_result = 1'b1;
        is_skip_form = 1'b1;
      end
      fra_pkg::increment_skip_zero_op: begin
        result = operand + fra_pkg::DATA_ONE;
        writes_result = 1'b1;
        is_skip_form = 1'b1;
      end
      default: begin
        result = operand; // Jump and idle write nothing
      end
    endcase
  end

  // Zero test spans the full eight-bit result
  assign result_zero = (result == fra_pkg::DATA_ZERO);
  // Skip only on a zero result; nonzero lets the next instruction run
  assign skip_now = take && is_skip_form && result_zero;
  assign file_wr = take && writes_result && (dest_i == fra_pkg::DEST_FILE);

  // File registers; an executing write beats a preload to the same slot
  // Preload is meant for setup, between instructions
  for (genvar i = 0; i < fra_pkg::FILE_DEPTH; i++) begin : g_file
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        file_q[i] <= fra_pkg::FILE_RST;
      end else if (file_wr && (file_addr_i == fra_pkg::ADDR_W'(i))) begin
        file_q[i] <= result;
      end else if (load_valid_i && (load_addr_i == fra_pkg::ADDR_W'(i))) begin
        file_q[i] <= load_data_i;
      end
    end
  end

  // Accumulator takes the result when the target bit selects it
  // Jump and idle never reach it, so a discarded slot leaves it as it was
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accum_q <= fra_pkg::ACCUM_RST;
    end else if (take && writes_result && (dest_i == fra_pkg::DEST_ACCUM)) begin
      accum_q <= result;
    end
  end

  // Zero flag: only the plain forms touch it; skip forms and jump leave it
  // Held as a level; nothing else in the block clears it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zero_q <= fra_pkg::ZERO_RST;
    end else if (take && sets_zero) begin
      zero_q <= result_zero;
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // Jump and a taken skip claim the following slot
      fra_pkg::ST_READY: begin
        if (take && (is_jump || skip_now)) begin
          state_d = fra_pkg::ST_SECOND;
        end
      end
      // Nothing is taken until the second slot has run out
      fra_pkg::ST_SECOND: begin
        if (tcy_en_q) begin
          state_d = fra_pkg::ST_READY;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= fra_pkg::ST_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // Remembers whether the second cycle is a discarded fetch or a jump refill
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      second_skips_q <= 1'b0;
    end else if (take) begin
      second_skips_q <= skip_now;
    end
  end

  // Program counter; a skipped instruction still consumes its address
  // Jump refills in its first slot, so its second slot leaves pc alone
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_q <= fra_pkg::PC_RST;
    end else if (take && is_jump) begin
      pc_q <= {upper_jump_latch_i[fra_pkg::LATCH_HI_BIT:fra_pkg::LATCH_LO_BIT], literal_i};
    end else if (take) begin
      pc_q <= pc_q + fra_pkg::PC_STEP;
    end else if (second_end && second_skips_q) begin
      pc_q <= pc_q + fra_pkg::PC_STEP;
    end
  end

  // Busy level covers the whole second slot of a jump or a taken skip
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d == fra_pkg::ST_SECOND);
    end
  end

  // Taken pulse follows the taking edge by one clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= take;
    end
  end

  // Skip pulse rides with taken, so the issuer can drop its fetch
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_now;
    end
  end

  // Done pulse: at once for one-cycle forms, else at the end of the second slot
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (take && (state_d == fra_pkg::ST_READY)) || second_end;
    end
  end

  // Registered observation port for the file registers
  // One clock of latency keeps the wide read mux away from the output
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      peek_q <= fra_pkg::FILE_RST;
    end else begin
      peek_q <= file_q[peek_addr_i];
    end
  end

  // Every output comes straight from its flip-flop
  assign peek_data_o = peek_q;
  assign accum_o = accum_q;
  assign zero_flag_o = zero_q;
  assign pc_o = pc_q;
  assign busy_o = busy_q;
  assign taken_o = taken_q;
  assign skip_o = skip_q;
  assign done_o = done_q;

endmodule : fra_file_reg_alu

// File: fra_pkg.sv
/*
  Shared constants for the file-register ALU and branch block: widths,
  operation codes, sequencer states, reset values and instruction-cycle timing.
  Assumes a single 50 MHz system clock and one instruction issued per cycle slot.
*/
package fra_pkg;

  // Clock and instruction-cycle timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TCY_NS = 80;
  localparam int TCY_CLKS = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Datapath widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int LIT_W = 11;
  localparam int PC_W = 13;
  localparam int LATCH_W = 8;
  localparam int FILE_DEPTH = 128;

  // Upper jump latch field that feeds the top of the program counter
  localparam int LATCH_HI_BIT = 4;
  localparam int LATCH_LO_BIT = 3;

  // Target select encoding
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Reset values and step sizes
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic ZERO_RST = 1'b0;

  // Operation codes presented on the issue port
  typedef enum logic [2:0] {
    idle_op = 3'h0,
    complement_op = 3'h1,
    jump_op = 3'h2,
    decrement_op = 3'h3,
    increment_op = 3'h4,
    decrement_skip_zero_op = 3'h5,
    increment_skip_zero_op = 3'h6
  } fra_op_e;

  // Sequencer: ready for a new instruction, or inside a second cycle
  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_SECOND = 2'b10
  } fra_state_e;

endpackage : fra_pkg

// File: fra_chk.sv
/*
  Port checker for fra_file_reg_alu, bound to every instance.
  Assumes the default four-clock instruction slot.
*/
`timescale 1ns/10ps
module fra_chk #(
  parameter int TCY_CLKS = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] accum_o,
  input wire logic zero_flag_o,
  input wire logic [12:0] pc_o,
  input wire logic busy_o,
  input wire logic taken_o,
  input wire logic skip_o,
  input wire logic done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Skip: one discarded slot, pc steps once more, flags kept
  property p_skip_slot; skip_o |-> taken_o ##0 busy_o [*4] ##1 (done_o && !busy_o); endproperty
  a_skip_slot: assert property (p_skip_slot) else $error("skip slot length wrong");
  property p_skip_pc; skip_o |-> ##4 pc_o == $past(pc_o, 4) + 13'h0001; endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip pc step wrong");
  property p_skip_flag; skip_o |-> zero_flag_o == $past(zero_flag_o); endproperty
  a_skip_flag: assert property (p_skip_flag) else $error("skip touched zero");
  // One-cycle ops finish at once and step pc by one
  property p_one_cycle; taken_o && !busy_o |-> done_o && pc_o == $past(pc_o) + 13'h0001; endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("single cycle op wrong");
  // Jump keeps zero and holds its target through the second slot
  property p_jump_hold; taken_o && busy_o && !skip_o |-> zero_flag_o == $past(zero_flag_o)
    ##4 done_o && pc_o == $past(pc_o, 4); endproperty
  a_jump_hold: assert property (p_jump_hold) else $error("jump second cycle wrong");
  property p_zero_src; $changed(zero_flag_o) |-> taken_o && !busy_o; endproperty
  a_zero_src: assert property (p_zero_src) else $error("zero changed off a take");
  // Discarded slot must not touch the accumulator
  property p_idle_acc; busy_o && !taken_o |-> $stable(accum_o); endproperty
  a_idle_acc: assert property (p_idle_acc) else $error("accum moved in idle slot");
  property p_pc_src; $changed(pc_o) |-> taken_o || done_o; endproperty
  a_pc_src: assert property (p_pc_src) else $error("pc moved unprompted");
endmodule : fra_chk

bind fra_file_reg_alu fra_chk #(.TCY_CLKS(TCY_CLKS)) u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .accum_o(accum_o), .zero_flag_o(zero_flag_o), .pc_o(pc_o), .busy_o(busy_o), .taken_o(taken_o),
  .skip_o(skip_o), .done_o(done_o));

// File: fra_file_reg_alu_test.sv
/*
  Self-checking bench for fra_file_reg_alu with a reference model.
  Assumes the default four-clock slot and a single clock.
*/
`timescale 1ns/10ps
module fra_file_reg_alu_test;
  typedef struct packed {logic [7:0] acc; logic z; logic [12:0] pc; logic sk; logic [7:0] f;} fra_exp_s;
  logic clk_i = 1'b0, reset_n_i = 1'b0, issue_valid_i = 1'b0, dest_i = 1'b0, load_valid_i = 1'b0;
  logic [2:0] issue_op_i = 3'h0;
  logic [6:0] file_addr_i = 7'h00, load_addr_i = 7'h00, peek_addr_i = 7'h00;
  logic [10:0] literal_i = 11'h000;
  logic [7:0] upper_jump_latch_i = 8'h00, load_data_i = 8'h00, accum_o, peek_data_o;
  logic [12:0] pc_o;
  logic zero_flag_o, busy_o, taken_o, skip_o, done_o;
  logic [7:0] mem [128];
  logic [7:0] sp [3] = '{8'h00, 8'h01, 8'hFF};
  logic [7:0] acc = 8'h00;
  logic z = 1'b0;
  logic [12:0] pc = 13'h0000;
  fra_exp_s exp_q [$];
  int failures = 0, check_count = 0;

  fra_file_reg_alu dut (.clk_i, .reset_n_i, .issue_valid_i, .issue_op_i, .file_addr_i, .dest_i, .literal_i,
    .upper_jump_latch_i, .load_valid_i, .load_addr_i, .load_data_i, .peek_addr_i, .peek_data_o, .accum_o,
    .zero_flag_o, .pc_o, .busy_o, .taken_o, .skip_o, .done_o);

  // 50 MHz clock
  initial forever #10 clk_i = ~clk_i;

  task automatic check(string name, logic [15:0] seen, logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Preload one file register, mirrored in the model
  task automatic load(logic [6:0] a, logic [7:0] v);
    @(negedge clk_i);
    load_valid_i = 1'b1;
    load_addr_i = a;
    load_data_i = v;
    mem[a] = v;
    @(negedge clk_i);
    load_valid_i = 1'b0;
  endtask : load

  // Model one op, note the outcome, then issue and wait for completion
  task automatic run(logic [2:0] op, logic [6:0] a, logic d, logic [10:0] k, logic [7:0] lt);
    logic [7:0] r;
    logic sk;
    int n;
    r = mem[a];
    case (op)
      3'h1: r = ~r;
      3'h3, 3'h5: r = r - 8'h01;
      3'h4, 3'h6: r = r + 8'h01;
      default: ;
    endcase
    if (op inside {3'h1, [3'h3:3'h6]}) begin
      if (d) mem[a] = r;
      else acc = r;
    end
    if (op inside {3'h1, 3'h3, 3'h4}) z = (r == 8'h00);
    sk = op inside {3'h5, 3'h6} && r == 8'h00;
    pc = (op == 3'h2) ? {lt[4:3], k} : pc + (sk ? 13'h0002 : 13'h0001);
    exp_q.push_back({acc, z, pc, sk, mem[a]});
    @(negedge clk_i);
    issue_valid_i = 1'b1;
    issue_op_i = op;
    file_addr_i = a;
    dest_i = d;
    literal_i = k;
    upper_jump_latch_i = lt;
    peek_addr_i = a;
    // Requests hold until the design takes them
    for (n = 0; n < 20 && taken_o !== 1'b1; n++) @(negedge clk_i);
    issue_valid_i = 1'b0;
    for (n = 0; n < 20 && done_o !== 1'b1; n++) @(negedge clk_i);
    repeat (2) @(negedge clk_i);
  endtask : run

  // Monitor: skip seen at take, results compared at completion
  initial begin
    fra_exp_s e;
    logic sk;
    forever begin
      @(negedge clk_i);
      if (taken_o === 1'b1) sk = skip_o;
      if (done_o === 1'b1 && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check("accum", accum_o, e.acc);
        check("zero", zero_flag_o, e.z);
        check("pc", pc_o, e.pc);
        check("skip", sk, e.sk);
        // Peek lags one clock behind the file write
        @(negedge clk_i);
        check("file", peek_data_o, e.f);
      end
    end
  end

  // Main sequence: reset, preload, corners, then random ops
  initial begin
    logic [6:0] a;
    void'($urandom(32'hA190));
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    check("pc_rst", pc_o, 16'h0000);
    for (int i = 0; i < 128; i++) load(7'(i), 8'($urandom));
    run(3'h2, 7'h7F, 1'b0, 11'h7FF, 8'h18);
    run(3'h2, 7'h00, 1'b1, 11'h555, 8'hE7);
    load(7'h10, 8'h01);
    run(3'h5, 7'h10, 1'b1, 11'h000, 8'h00);
    load(7'h11, 8'hFF);
    run(3'h6, 7'h11, 1'b0, 11'h000, 8'h00);
    run(3'h5, 7'h11, 1'b0, 11'h000, 8'h00);
    load(7'h12, 8'hFF);
    run(3'h1, 7'h12, 1'b1, 11'h000, 8'h00);
    for (int i = 0; i < 90; i++) begin
      a = 7'($urandom);
      if ($urandom % 2 == 0) load(a, sp[$urandom % 3]);
      run(3'($urandom), a, 1'($urandom), 11'($urandom), 8'($urandom));
    end
    // Every noted instruction must have completed and been compared
    check("pending", 16'(exp_q.size()), 16'h0000);
    give_verdict();
  end

  // Watchdog well past the expected run length
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule : fra_file_reg_alu_test
